// >>> rtl/fpe_pkg.sv
// package of the flash program/erase interface: register map, keys, field
// positions, states, bus and port carriers, erase block table.
// assumes 8-bit registers, one per aligned 32-bit wishbone word.
package fpe_pkg;

    // register byte offsets
    localparam logic [7:0] FPE_OFS_CCS     = 8'h00; // code_control_status_reg
    localparam logic [7:0] FPE_OFS_KEY     = 8'h04; // flash_key_code_reg
    localparam logic [7:0] FPE_OFS_DEST    = 8'h08; // download_dest_addr_reg
    localparam logic [7:0] FPE_OFS_VBINIT  = 8'h0c; // vector base initialised
    localparam logic [7:0] FPE_OFS_DLRES   = 8'h10; // download result
    localparam logic [7:0] FPE_OFS_FREQ    = 8'h14; // cpu frequency, MHz
    localparam logic [7:0] FPE_OFS_ADDR0   = 8'h18; // target address [7:0]
    localparam logic [7:0] FPE_OFS_ADDR1   = 8'h1c; // target address [15:8]
    localparam logic [7:0] FPE_OFS_ADDR2   = 8'h20; // target address [18:16]
    localparam logic [7:0] FPE_OFS_DATA    = 8'h24; // program data port
    localparam logic [7:0] FPE_OFS_BLOCK   = 8'h28; // erase block number
    localparam logic [7:0] FPE_OFS_OPCTL   = 8'h2c; // operation start
    localparam logic [7:0] FPE_OFS_OPRES   = 8'h30; // operation result
    localparam logic [7:0] FPE_OFS_EMU     = 8'h34; // ram overlay emulation
    localparam logic [7:0] FPE_OFS_IRQ_ST  = 8'h38; // interrupt status, ro
    localparam logic [7:0] FPE_OFS_IRQ_EN  = 8'h3c; // interrupt enable
    localparam logic [7:0] FPE_OFS_IRQ_CLR = 8'h40; // interrupt clear, wo

    // field positions
    localparam int FPE_CCS_FIXED  = 7;   // reads as one
    localparam int FPE_CCS_ERR    = 4;   // flash_error_flag
    localparam int FPE_CCS_REQ    = 0;   // download request, reads busy
    localparam int FPE_OP_PROG    = 0;
    localparam int FPE_OP_ERASE   = 1;
    localparam int FPE_EMU_EN     = 3;
    localparam int FPE_IRQ_DL     = 0;   // download finished
    localparam int FPE_IRQ_OP     = 1;   // operation finished
    localparam int FPE_IRQ_ERR    = 2;   // error protection entered

    // keys and result codes
    localparam logic [7:0] FPE_KEY_DL   = 8'ha5;
    localparam logic [7:0] FPE_KEY_PE   = 8'h5a;
    localparam logic [7:0] FPE_RES_PASS = 8'h00;
    localparam logic [7:0] FPE_RES_FAIL = 8'h01;
    localparam logic [7:0] FPE_CCS_RST  = 8'h80;

    // sizes
    localparam int         FPE_UNIT_BYTES = 128;
    localparam int         FPE_ROM_BYTES  = 64;   // embedded routine length
    localparam logic [7:0] FPE_DEST_MAX   = 8'h3f;
    localparam logic [3:0] FPE_BLK_LAST   = 4'hf;
    localparam logic [6:0] FPE_UNIT_LOW   = 7'h00; // unit alignment bits
    localparam logic [11:0] FPE_PULSE_MUL = 12'h010; // program pulse cycles per MHz; erase pulses 16 times longer

    typedef enum logic [1:0] {
        FPE_IDLE   = 2'b00,
        FPE_DLOAD  = 2'b01,
        FPE_STREAM = 2'b11,
        FPE_PULSE  = 2'b10
    } fpe_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } fpe_wb_req_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } fpe_ram_wr_t;

    typedef struct packed {
        logic        prog;     // program pulse
        logic        erase;    // erase pulse
        logic        we;       // data byte strobe
        logic [18:0] addr;
        logic [7:0]  wdata;
        logic [18:0] blk_base;
        logic [18:0] blk_last;
    } fpe_flash_cmd_t;

    // base of an erase block: 0-7 are 4K, 8 is 32K, 9-15 are 64K
    function automatic logic [18:0] fpe_blk_base(input logic [3:0] n);
        logic [18:0] b;
        b = 19'h00000;
        if (n < 4'h8) begin
            b = {3'h0, n, 12'h000};
        end else if (n == 4'h8) begin
            b = 19'h08000;
        end else begin
            b = {n - 4'h8, 15'h0000} << 1;
        end
        return b;
    endfunction

    function automatic logic [18:0] fpe_blk_last(input logic [3:0] n);
        logic [18:0] l;
        l = 19'h00000;
        if (n < 4'h8) begin
            l = fpe_blk_base(n) + 19'h00fff;
        end else if (n == 4'h8) begin
            l = 19'h0ffff;
        end else begin
            l = fpe_blk_base(n) + 19'h0ffff;
        end
        return l;
    endfunction

endpackage

// >>> rtl/fpe_flash_if.sv
// flash program/erase interface: wishbone register slave, embedded routine
// download engine, program data buffer, program/erase sequencer, overlay.
// assumes a single 25 MHz clock, synchronous active-high reset, and a cpu
// that runs its procedure code from on-chip ram while the array is busy.
`timescale 1ns/100ps

module fpe_flash_if
    import fpe_pkg::*;
(
    // clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // wishbone slave
    input  wire fpe_wb_req_t    wb_req_i,
    output logic                wb_ack_o,
    output logic [31:0]         wb_dat_o,
    // ram write port for the download
    output fpe_ram_wr_t         ram_wr_o,
    // flash core
    output fpe_flash_cmd_t      flash_cmd_o,
    input  wire logic           flash_fail_i,
    // system effects
    output logic                map_embedded_o,
    output logic                array_rd_block_o,
    output logic                cpu_irq_mask_o,
    output logic                emu_en_o,
    output logic [18:0]         emu_base_o,
    output logic                irq_o
);

    fpe_state_t  state_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [7:0]  key_q;
    logic [7:0]  dest_q;
    logic        vbinit_q;
    logic [7:0]  dlres_q;
    logic [7:0]  freq_q;
    logic [18:0] addr_q;
    logic [3:0]  blk_q;
    logic [7:0]  opres_q;
    logic [3:0]  emu_q;
    logic        err_q;
    logic [2:0]  ist_q;
    logic [2:0]  ien_q;
    logic [6:0]  didx_q;
    logic [6:0]  cnt_q;
    logic [19:0] pulse_q;
    logic        is_prog_q;
    logic [7:0]  buf_q [FPE_UNIT_BYTES];
    fpe_ram_wr_t ram_wr_q;
    fpe_flash_cmd_t cmd_q;

    logic        wr_en;
    logic        rd_en;
    logic        dl_start;
    logic        dl_done;
    logic        op_start_p;
    logic        op_start_e;
    logic        op_done;
    logic        op_err;
    logic [2:0]  ev;

    // a write lands at the edge where ack is seen; byte lane 0 only
    // byte access
    assign wr_en = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_q & (wb_req_i.sel == 4'h1);
    assign rd_en = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_q;

    // download request decoding
    // automatic download
    assign dl_start = wr_en & (wb_req_i.adr == FPE_OFS_CCS) & wb_req_i.dat[FPE_CCS_REQ]
                    & (key_q == FPE_KEY_DL) & vbinit_q & (state_q == FPE_IDLE);

    // operation start, refused while locked or without the program key
    // error lockout
    assign op_start_p = wr_en & (wb_req_i.adr == FPE_OFS_OPCTL) & wb_req_i.dat[FPE_OP_PROG]
                      & (key_q == FPE_KEY_PE) & ~err_q & (state_q == FPE_IDLE);
    assign op_start_e = wr_en & (wb_req_i.adr == FPE_OFS_OPCTL) & wb_req_i.dat[FPE_OP_ERASE]
                      & ~wb_req_i.dat[FPE_OP_PROG] & (key_q == FPE_KEY_PE) & ~err_q
                      & (state_q == FPE_IDLE);

    // a program start that breaks the unit alignment is an error
    // unit alignment
    assign op_err = (op_start_p & (addr_q[6:0] != FPE_UNIT_LOW))
                  | ((state_q == FPE_PULSE) & flash_fail_i);

    assign dl_done = (state_q == FPE_DLOAD)
                   & ((dest_q > FPE_DEST_MAX) | (didx_q == 7'(FPE_ROM_BYTES - 1)));
    assign op_done = (state_q == FPE_PULSE) & (pulse_q == 20'h00000);
    assign ev      = {op_err, op_done, dl_done};

    // wishbone answer one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req_i.cyc & wb_req_i.stb & ~ack_q;
        end
    end

    // read data captured with the request; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h00000000;
        end else if (rd_en) begin
            rdat_q <= 32'h00000000;
            unique case (wb_req_i.adr)
                FPE_OFS_CCS:    rdat_q[7:0] <= FPE_CCS_RST | ({7'h00, err_q} << FPE_CCS_ERR)
                                             | {7'h00, state_q == FPE_DLOAD};
                FPE_OFS_KEY:    rdat_q[7:0] <= key_q;
                FPE_OFS_DEST:   rdat_q[7:0] <= dest_q;
                FPE_OFS_VBINIT: rdat_q[7:0] <= {7'h00, vbinit_q};
                FPE_OFS_DLRES:  rdat_q[7:0] <= dlres_q;
                FPE_OFS_FREQ:   rdat_q[7:0] <= freq_q;
                FPE_OFS_ADDR0:  rdat_q[7:0] <= addr_q[7:0];
                FPE_OFS_ADDR1:  rdat_q[7:0] <= addr_q[15:8];
                FPE_OFS_ADDR2:  rdat_q[7:0] <= {5'h00, addr_q[18:16]};
                FPE_OFS_BLOCK:  rdat_q[7:0] <= {4'h0, blk_q};
                FPE_OFS_OPCTL:  rdat_q[7:0] <= {7'h00, state_q != FPE_IDLE};
                FPE_OFS_OPRES:  rdat_q[7:0] <= opres_q;
                FPE_OFS_EMU:    rdat_q[7:0] <= {4'h0, emu_q};
                FPE_OFS_IRQ_ST: rdat_q[7:0] <= {5'h00, ist_q};
                FPE_OFS_IRQ_EN: rdat_q[7:0] <= {5'h00, ien_q};
                default:        rdat_q      <= 32'h00000000;
            endcase
        end
    end

    // download setup registers
    // destination register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_q    <= 8'h00;
            dest_q   <= 8'h00;
            vbinit_q <= 1'b0;
        end else if (wr_en) begin
            if (wb_req_i.adr == FPE_OFS_KEY) begin
                key_q <= wb_req_i.dat[7:0];
            end
            if (wb_req_i.adr == FPE_OFS_DEST && state_q != FPE_DLOAD) begin
                dest_q <= wb_req_i.dat[7:0];
            end
            if (wb_req_i.adr == FPE_OFS_VBINIT) begin
                vbinit_q <= wb_req_i.dat[0];
            end
        end
    end

    // operation parameters, frozen while an operation runs
    // parameters persist
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_q <= 8'h00;
            addr_q <= 19'h00000;
            blk_q  <= 4'h0;
            emu_q  <= 4'h0;
        end else if (wr_en && state_q == FPE_IDLE) begin
            unique case (wb_req_i.adr)
                FPE_OFS_FREQ:  freq_q         <= wb_req_i.dat[7:0];
                FPE_OFS_ADDR0: addr_q[7:0]    <= wb_req_i.dat[7:0];
                FPE_OFS_ADDR1: addr_q[15:8]   <= wb_req_i.dat[7:0];
                FPE_OFS_ADDR2: addr_q[18:16]  <= wb_req_i.dat[2:0];
                FPE_OFS_BLOCK: blk_q          <= wb_req_i.dat[3:0];
                FPE_OFS_EMU:   emu_q          <= wb_req_i.dat[3:0];
                default:       freq_q         <= freq_q;
            endcase
        end
    end

    // overlay: 3-bit block select reaches only the 4K blocks
    // overlay range
    assign emu_en_o   = emu_q[FPE_EMU_EN];
    assign emu_base_o = fpe_blk_base({1'b0, emu_q[2:0]});

    // program data buffer, filled in order through the data port
    always_ff @(posedge clk_i) begin
        if (wr_en && wb_req_i.adr == FPE_OFS_DATA && state_q == FPE_IDLE) begin
            buf_q[cnt_q] <= wb_req_i.dat[7:0];
        end
    end

    // fill index for the buffer, rewound by an operation start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 7'h00;
        end else if (op_start_p || op_start_e) begin
            cnt_q <= 7'h00;
        end else if (wr_en && wb_req_i.adr == FPE_OFS_DATA && state_q == FPE_IDLE) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    // sequencer: download copy, data stream, pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q   <= FPE_IDLE;
            didx_q    <= 7'h00;
            pulse_q   <= 20'h00000;
            is_prog_q <= 1'b0;
        end else begin
            unique case (state_q)
                FPE_IDLE: begin
                    didx_q <= 7'h00;
                    if (dl_start) begin
                        state_q <= FPE_DLOAD;
                    end else if (op_start_p && !op_err) begin
                        is_prog_q <= 1'b1;
                        state_q   <= FPE_STREAM;
                    end else if (op_start_e && blk_q <= FPE_BLK_LAST) begin
                        is_prog_q <= 1'b0;
                        pulse_q   <= 20'({freq_q, 12'h000} >> 8) * 20'(FPE_PULSE_MUL) + 20'h00001;
                        state_q   <= FPE_PULSE;
                    end
                end
                FPE_DLOAD: begin
                    didx_q <= didx_q + 7'h01;
                    if (dl_done) begin
                        state_q <= FPE_IDLE;
                    end
                end
                FPE_STREAM: begin
                    didx_q <= didx_q + 7'h01;
                    if (didx_q == 7'(FPE_UNIT_BYTES - 1)) begin
                        pulse_q <= 20'(freq_q) * 20'(FPE_PULSE_MUL) + 20'h00001;
                        state_q <= FPE_PULSE;
                    end
                end
                FPE_PULSE: begin
                    pulse_q <= pulse_q - 20'h00001;
                    if (op_done || flash_fail_i) begin
                        state_q <= FPE_IDLE;
                    end
                end
            endcase
        end
    end

    // embedded routine copy into ram at the destination page
    // ram start address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_wr_q <= '0;
        end else begin
            ram_wr_q.we   <= (state_q == FPE_DLOAD) & (dest_q <= FPE_DEST_MAX);
            ram_wr_q.addr <= {dest_q, 8'h00} + {9'h000, didx_q};
            ram_wr_q.data <= {didx_q[5:0], 2'b01} ^ 8'h96;
        end
    end
    assign ram_wr_o = ram_wr_q;

    // download result, left for software to check
    // download result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlres_q <= FPE_RES_PASS;
        end else if (dl_done) begin
            dlres_q <= (dest_q > FPE_DEST_MAX) ? FPE_RES_FAIL : FPE_RES_PASS;
        end
    end

    // operation result and sticky error protection
    // pass/fail result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opres_q <= FPE_RES_PASS;
            err_q   <= 1'b0;
        end else begin
            if (op_err || (op_start_e && blk_q > FPE_BLK_LAST)) begin
                opres_q <= FPE_RES_FAIL;
                err_q   <= 1'b1;
            end else if (op_done) begin
                opres_q <= FPE_RES_PASS;
            end
        end
    end

    // flash core command, one data byte per cycle then the pulse
    // block bounds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else begin
            cmd_q.we       <= (state_q == FPE_STREAM);
            cmd_q.wdata    <= buf_q[didx_q];
            cmd_q.addr     <= {addr_q[18:7], didx_q};
            cmd_q.prog     <= (state_q == FPE_PULSE) & is_prog_q & ~op_done;
            cmd_q.erase    <= (state_q == FPE_PULSE) & ~is_prog_q & ~op_done;
            cmd_q.blk_base <= fpe_blk_base(blk_q);
            cmd_q.blk_last <= fpe_blk_last(blk_q);
        end
    end
    assign flash_cmd_o = cmd_q;

    // array mapping, read blocking and cpu interrupt masking
    // embedded map
    assign map_embedded_o   = (state_q == FPE_DLOAD);
    assign array_rd_block_o = (state_q == FPE_STREAM) | (state_q == FPE_PULSE);
    assign cpu_irq_mask_o   = (state_q == FPE_STREAM) | (state_q == FPE_PULSE);

    // sticky event status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= 3'h0;
            ien_q <= 3'h0;
        end else begin
            if (wr_en && wb_req_i.adr == FPE_OFS_IRQ_CLR) begin
                ist_q <= (ist_q & ~wb_req_i.dat[2:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
            if (wr_en && wb_req_i.adr == FPE_OFS_IRQ_EN) begin
                ien_q <= wb_req_i.dat[2:0];
            end
        end
    end

    assign irq_o    = |(ist_q & ien_q);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule

// >>> test/fpe_flash_if_assertions.sv
// checker for the flash program/erase interface ports.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps

module fpe_flash_if_chk
    import fpe_pkg::*;
(
    // clock and reset
    input wire logic           clk_i,
    input wire logic           rst_i,
    // register bus
    input wire fpe_wb_req_t    wb_req_i,
    input wire logic           wb_ack_o,
    input wire logic [31:0]    wb_dat_o,
    // download and flash side
    input wire fpe_ram_wr_t    ram_wr_o,
    input wire fpe_flash_cmd_t flash_cmd_o,
    input wire logic           flash_fail_i,
    // system effects
    input wire logic           map_embedded_o,
    input wire logic           array_rd_block_o,
    input wire logic           cpu_irq_mask_o,
    input wire logic           emu_en_o,
    input wire logic [18:0]    emu_base_o,
    input wire logic           irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next_edge: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    a_read_byte_wide: assert property (wb_ack_o && !wb_req_i.we |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data wider than one byte");
    a_core_masked: assert property (flash_cmd_o.we || flash_cmd_o.prog || flash_cmd_o.erase |->
        cpu_irq_mask_o && array_rd_block_o)
        else $error("flash core active with interrupts or reads open");
    a_pulse_masked: assert property ($rose(flash_cmd_o.prog || flash_cmd_o.erase) |-> cpu_irq_mask_o)
        else $error("pulse started with interrupts open");
    a_map_not_busy: assert property (map_embedded_o |-> !array_rd_block_o)
        else $error("embedded map during program or erase");
    a_ram_in_load: assert property (ram_wr_o.we |-> $past(map_embedded_o))
        else $error("ram write outside download");
    a_unit_aligned: assert property ($rose(flash_cmd_o.we) |-> flash_cmd_o.addr[6:0] == 7'h00)
        else $error("program stream starts off a unit boundary");
    a_block_size: assert property (flash_cmd_o.erase |->
        (flash_cmd_o.blk_last - flash_cmd_o.blk_base) inside {19'h00fff, 19'h07fff, 19'h0ffff})
        else $error("erase range is not a whole block");
    a_emu_small_only: assert property (emu_en_o |-> emu_base_o < 19'h08000 && emu_base_o[11:0] == 12'h000)
        else $error("overlay outside the small blocks");

    c_download: cover property ($fell(map_embedded_o));
    c_program: cover property ($rose(flash_cmd_o.prog));
    c_erase: cover property ($rose(flash_cmd_o.erase));
    c_irq: cover property ($rose(irq_o));
endmodule

bind fpe_flash_if fpe_flash_if_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ram_wr_o(ram_wr_o), .flash_cmd_o(flash_cmd_o),
    .flash_fail_i(flash_fail_i), .map_embedded_o(map_embedded_o), .array_rd_block_o(array_rd_block_o),
    .cpu_irq_mask_o(cpu_irq_mask_o), .emu_en_o(emu_en_o), .emu_base_o(emu_base_o), .irq_o(irq_o));

// >>> test/fpe_flash_core_model.sv
// model of the flash core and download ram behind the interface.
// assumes reset, or a clr_i pulse from the bench, clears the counts before each counted operation.
`timescale 1ns/100ps

module fpe_flash_core_model
    import fpe_pkg::*;
(
    // clock and reset
    input wire logic           clk_i,
    input wire logic           rst_i,
    input wire logic           clr_i,
    // design side
    input wire fpe_ram_wr_t    ram_wr_i,
    input wire fpe_flash_cmd_t flash_cmd_i,
    output logic               flash_fail_o,
    // counts for the bench
    output logic [7:0]         ram_cnt_o,
    output logic [15:0]        first_ram_o,
    output logic [7:0]         wr_cnt_o,
    output logic [15:0]        pulse_cnt_o,
    output logic               data_bad_o
);
    // core never reports a failure in these runs
    assign flash_fail_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            ram_cnt_o   <= 8'h00;
            first_ram_o <= 16'h0000;
            wr_cnt_o    <= 8'h00;
            pulse_cnt_o <= 16'h0000;
            data_bad_o  <= 1'b0;
        end else begin
            // bench loads byte i at unit offset i, so data must equal the offset
            if (flash_cmd_i.we && flash_cmd_i.wdata != {1'b0, flash_cmd_i.addr[6:0]}) begin
                data_bad_o <= 1'b1;
            end
            if (ram_wr_i.we) begin
                ram_cnt_o <= ram_cnt_o + 8'h01;
                if (ram_cnt_o == 8'h00) first_ram_o <= ram_wr_i.addr;
            end
            if (flash_cmd_i.we) wr_cnt_o <= wr_cnt_o + 8'h01;
            if (flash_cmd_i.prog || flash_cmd_i.erase) pulse_cnt_o <= pulse_cnt_o + 16'h0001;
        end
    end
endmodule

// >>> test/tb_fpe_flash_if.sv
// self-checking bench: wishbone register tasks drive download, program,
// erase, overlay and interrupt sequences; flash core model on far side.
`timescale 1ns/100ps

module tb_fpe_flash_if;
    import fpe_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clr = 1'b0;
    fpe_wb_req_t req = '0;
    fpe_ram_wr_t ram_wr;
    fpe_flash_cmd_t flash_cmd_o;
    logic wb_ack_o, fail, map_embedded_o, array_rd_block_o, cpu_irq_mask_o, emu_en_o, irq_o;
    logic [31:0] wb_dat_o;
    logic [18:0] emu_base_o, bb, bl, eb, el;
    logic [7:0] ram_cnt, wr_cnt;
    logic [15:0] first_ram, pulse_cnt;
    logic seen, data_bad;
    int mismatches = 0;
    int checked = 0;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    fpe_flash_if uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .ram_wr_o(ram_wr), .flash_cmd_o(flash_cmd_o), .flash_fail_i(fail), .map_embedded_o(map_embedded_o),
        .array_rd_block_o(array_rd_block_o), .cpu_irq_mask_o(cpu_irq_mask_o), .emu_en_o(emu_en_o),
        .emu_base_o(emu_base_o), .irq_o(irq_o));
    fpe_flash_core_model core (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .ram_wr_i(ram_wr),
        .flash_cmd_i(flash_cmd_o), .flash_fail_o(fail), .ram_cnt_o(ram_cnt), .first_ram_o(first_ram),
        .wr_cnt_o(wr_cnt), .pulse_cnt_o(pulse_cnt), .data_bad_o(data_bad));

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask

    // one classic cycle, held until ack is sampled high at a rising edge;
    // data taken and request released at that same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h000000, v}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o[7:0];
        req <= '0;
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] r;
        xfer(1'b1, a, v, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        xfer(1'b0, a, 8'h00, r);
        chk({24'h0, r}, {24'h0, e});
    endtask

    task automatic clear_counts();
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
    endtask

    // wait for a download or operation to start and end
    task automatic wait_op();
        int n;
        seen = 1'b0;
        for (n = 0; n < 2000; n++) begin
            #1;
            if (map_embedded_o === 1'b1 || array_rd_block_o === 1'b1) seen = 1'b1;
            if (flash_cmd_o.erase === 1'b1) begin
                bb = flash_cmd_o.blk_base;
                bl = flash_cmd_o.blk_last;
            end
            if (seen && map_embedded_o === 1'b0 && array_rd_block_o === 1'b0) break;
            @(posedge clk_i);
        end
        if (n >= 2000) begin
            chk(32'h0, 32'h2);
            final_report();
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(FPE_OFS_CCS, FPE_CCS_RST);
        rdc(8'hf0, 8'h00);
        wr(FPE_OFS_VBINIT, 8'h01);
        wr(FPE_OFS_DEST, 8'h01);
        wr(FPE_OFS_KEY, 8'h00);
        wr(FPE_OFS_CCS, 8'h01);
        repeat (4) @(posedge clk_i);
        chk({31'h0, map_embedded_o}, 32'h0);
        chk({24'h0, ram_cnt}, 32'h0);
        wr(FPE_OFS_KEY, FPE_KEY_DL);
        wr(FPE_OFS_CCS, 8'h01);
        wait_op();
        rdc(FPE_OFS_DLRES, FPE_RES_PASS);
        chk({24'h0, ram_cnt}, 32'd64);
        chk({16'h0, first_ram}, 32'h0100);
        wr(FPE_OFS_IRQ_EN, 8'h01);
        #1 chk({31'h0, irq_o}, 32'h1);
        wr(FPE_OFS_IRQ_EN, 8'h00);
        #1 chk({31'h0, irq_o}, 32'h0);
        wr(FPE_OFS_IRQ_CLR, 8'h01);
        rdc(FPE_OFS_IRQ_ST, 8'h00);
        wr(FPE_OFS_DEST, 8'h40);
        wr(FPE_OFS_CCS, 8'h01);
        wait_op();
        rdc(FPE_OFS_DLRES, FPE_RES_FAIL);
        wr(FPE_OFS_FREQ, 8'h01);
        wr(FPE_OFS_KEY, FPE_KEY_PE);
        // every erase block with its span, erased before any programming
        // erase first
        for (int n = 0; n < 16; n++) begin
            eb = (n < 8) ? 19'(n) * 19'h01000 : (n == 8) ? 19'h08000 : 19'(n - 8) * 19'h10000;
            el = eb + ((n < 8) ? 19'h00fff : (n == 8) ? 19'h07fff : 19'h0ffff);
            wr(FPE_OFS_BLOCK, 8'(n));
            wr(FPE_OFS_OPCTL, 8'h02);
            wait_op();
            chk({13'h0, bb}, {13'h0, eb});
            chk({13'h0, bl}, {13'h0, el});
        end
        chk({13'h0, el}, 32'h07ffff);
        // two program units back to back, no new download
        for (int k = 0; k < 2; k++) begin
            wr(FPE_OFS_ADDR0, k[0] ? 8'h00 : 8'h80);
            wr(FPE_OFS_ADDR1, k[0] ? 8'h01 : 8'h00);
            wr(FPE_OFS_ADDR2, 8'h00);
            for (int i = 0; i < 128; i++) wr(FPE_OFS_DATA, 8'(i));
            clear_counts();
            wr(FPE_OFS_OPCTL, 8'h01);
            wait_op();
            rdc(FPE_OFS_OPRES, FPE_RES_PASS);
            chk({24'h0, wr_cnt}, 32'd128);
            chk({31'h0, data_bad}, 32'h0);
            chk({31'h0, pulse_cnt >= 16'd16 && pulse_cnt <= 16'd17}, 32'h1);
        end
        wr(FPE_OFS_EMU, 8'h0b);
        #1 chk({12'h0, emu_en_o, emu_base_o}, {12'h0, 1'b1, 19'h03000});
        // misaligned unit enters error protection
        wr(FPE_OFS_IRQ_EN, 8'h04);
        wr(FPE_OFS_ADDR0, 8'h40);
        clear_counts();
        wr(FPE_OFS_OPCTL, 8'h01);
        repeat (3) @(posedge clk_i);
        rdc(FPE_OFS_OPRES, FPE_RES_FAIL);
        rdc(FPE_OFS_CCS, 8'h90);
        #1 chk({31'h0, irq_o}, 32'h1);
        wr(FPE_OFS_BLOCK, 8'h00);
        wr(FPE_OFS_OPCTL, 8'h02);
        repeat (40) @(posedge clk_i);
        chk({8'h0, wr_cnt, pulse_cnt}, 32'h0);
        final_report();
    end
endmodule
